/* dv/pad_world.sv */
// pad model of the far side: resolves each general pin from device drive, outside driver and pull-up
`timescale 1ns/1ps

module pad_world (
  input  wire pin_mux_pkg::pin_drive_s pins,
  input  wire logic [2:0]              ext_drive,
  input  wire logic [2:0]              ext_level,
  output logic [2:0]                   pin_in
);
  import pin_mux_pkg::*;

  // an undriven pad floats to the pull-up level; a clash between drivers shows as unknown
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pins.oe[i] && ext_drive[i]) begin
        pin_in[i] = 1'bx;
      end else if (pins.oe[i]) begin
        pin_in[i] = pins.out[i];
      end else if (ext_drive[i]) begin
        pin_in[i] = ext_level[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule : pad_world

/* dv/settings_readback_gp_pin_mux_bench.sv */
// self-checking bench for the settings readback pin mux over its register bus
`timescale 1ns/1ps

module settings_readback_gp_pin_mux_bench;
  import pin_mux_pkg::*;

  logic        aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  pin_in, ext_drive, ext_level;
  logic        suspend_active, usb_configured, uart_rx_active, uart_tx_active;
  pin_drive_s  pins;
  analog_sel_s analog;
  usb_desc_s   usb_desc;
  int          num_errors, check_count, cycles;

  settings_readback_gp_pin_mux settings_readback_gp_pin_mux_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .suspend_active(suspend_active), .usb_configured(usb_configured),
    .uart_rx_active(uart_rx_active), .uart_tx_active(uart_tx_active),
    .pins(pins), .analog(analog), .usb_desc(usb_desc), .irq(irq)
  );

  pad_world pad_world_inst (.pins(pins), .ext_drive(ext_drive), .ext_level(ext_level), .pin_in(pin_in));

  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wvalid <= 1'b1;
    wdata <= d;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // read: rready held high until the answer is seen
  task automatic rdr(input logic [5:0] idx);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdr

  // pin outputs land one edge after the setting; a few cycles of margin
  task automatic set_pin(input int p, input logic [7:0] v);
    wr(IDX_PIN0 + 6'(p), {24'h00_0000, v});
    wait_cyc(3);
  endtask : set_pin

  // expected drive enable for a pin configured as input under a designation code
  function automatic logic exp_oe(input int p, input int c);
    if (p == 0) return (c == 1 || c == 2);
    if (p == 1) return (c == 1 || c == 3);
    return (c == 1);
  endfunction : exp_oe

  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    int toggles;
    logic prev;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    {ext_drive, ext_level} = 6'h00;
    {suspend_active, usb_configured, uart_rx_active, uart_tx_active} = 4'h0;
    clk_en = 1'b1;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    aresetn = 1'b0;
    wait_cyc(2);
    aresetn <= 1'b1;
    // reset values of settings and descriptor outputs
    rdr(IDX_PIN0);
    chk("pin0 reset", rd, 32'h0000_0000);
    chk("desc reset", 32'(usb_desc), 32'h0000_0000);
    // identifiers, low byte first
    wr(IDX_VID_LO, 32'h0000_0034);
    wr(IDX_VID_HI, 32'h0000_0012);
    wr(IDX_PID_LO, 32'h0000_00cd);
    wr(IDX_PID_HI, 32'h0000_00ab);
    wr(IDX_POWER, 32'h0000_00a0);
    wr(IDX_CURRENT, 32'h0000_00ff);
    wait_cyc(2);
    chk("vendor", 32'(usb_desc.vendor_id), 32'h0000_1234);
    chk("product", 32'(usb_desc.product_id), 32'h0000_abcd);
    chk("power attr", 32'(usb_desc.power_attributes), 32'h0000_00a0);
    chk("current mA", 32'(usb_desc.current_ma), 32'h0000_01fe);
    // password bytes 1 to 8 in order
    for (int i = 0; i < 8; i++) begin
      wr(IDX_PW1 + 6'(i), 32'(8'h11 * (i + 1)));
    end
    for (int i = 0; i < 8; i++) begin
      rdr(IDX_PW1 + 6'(i));
      chk("password byte", rd, 32'(8'h11 * (i + 1)));
    end
    // unmapped place answers with an error and no data
    rdr(6'h3f);
    chk("unmapped read resp", 32'(rsp), 32'(RESP_SLVERR));
    chk("unmapped read data", rd, 32'h0000_0000);
    wr(6'h3f, 32'h0000_00ff);
    chk("unmapped write resp", 32'(rsp), 32'(RESP_SLVERR));
    // gpio output with ignored upper bits set
    set_pin(0, 8'hf0);
    chk("gpio out level", 32'(pins.out[0]), 32'h0000_0001);
    chk("gpio out enable", 32'(pins.oe[0]), 32'h0000_0001);
    set_pin(0, 8'he8);
    chk("gpio input enable", 32'(pins.oe[0]), 32'h0000_0000);
    // designation table with the direction bit set to input
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 8; c++) begin
        set_pin(p, 8'(8'h08 | c));
        chk("pin drive", 32'(pins.oe[p]), 32'(exp_oe(p, c)));
        chk("adc1 sel", 32'(analog.adc1_sel), 32'(p == 1 && c == 2));
        chk("analog_input_channel_two sel", 32'(analog.analog_input_channel_two_sel), 32'(p == 2 && c == 2));
        chk("analog_output_channel_one sel", 32'(analog.analog_output_channel_one_sel), 32'(p == 2 && c == 3));
      end
      set_pin(p, 8'h08);
    end
    // all three released: pull-ups on the synchronised inputs, nothing driven or selected
    rdr(IDX_PIN_STATE);
    chk("pin state", rd, 32'h0000_0007);
    wr(IDX_PIN_STATE, 32'h0000_0fff);
    chk("pin state write resp", 32'(rsp), 32'(RESP_OKAY));
    // indicators: idle level, inverted while active
    wr(IDX_CTRL, 32'h0000_0200);
    set_pin(1, 8'h03);
    chk("tx idle", 32'(pins.out[1]), 32'h0000_0001);
    uart_tx_active <= 1'b1;
    wait_cyc(3);
    chk("tx active", 32'(pins.out[1]), 32'h0000_0000);
    uart_tx_active <= 1'b0;
    set_pin(0, 8'h02);
    uart_rx_active <= 1'b1;
    wait_cyc(3);
    chk("rx active", 32'(pins.out[0]), 32'h0000_0001);
    suspend_active <= 1'b1;
    set_pin(0, 8'h01);
    chk("suspend out", 32'(pins.out[0]), 32'h0000_0001);
    usb_configured <= 1'b1;
    set_pin(2, 8'h01);
    chk("configured out", 32'(pins.out[2]), 32'h0000_0001);
    // clock output, dividers 2 then 1: a change every D cycles
    for (int dv = 2; dv >= 1; dv--) begin
      wr(IDX_CTRL, 32'(dv));
      set_pin(1, 8'h01);
      #1;
      toggles = 0;
      prev = pins.out[1];
      repeat (40) begin
        @(posedge aclk);
        #1;
        if (pins.out[1] !== prev) toggles++;
        prev = pins.out[1];
      end
      chk("clock toggles", 32'(toggles), 32'(40 / dv));
    end
    // clock enable low freezes the divider and the pin
    @(posedge aclk);
    clk_en <= 1'b0;
    wait_cyc(2);
    prev = pins.out[1];
    wait_cyc(5);
    chk("frozen clock", 32'(pins.out[1]), 32'(prev));
    clk_en <= 1'b1;
    // edge detection: rising enabled first, then falling only; status sticky and W1C, mask gates irq
    // release the pin with both edge enables off, so its pull-up rise is no edge
    wr(IDX_MASK, 32'h0000_0001);
    set_pin(1, 8'h04);
    wr(IDX_CTRL, 32'h0000_0020);
    ext_drive[1] <= 1'b1;
    wait_cyc(8);
    rdr(IDX_STATUS);
    chk("no flag on fall", rd, 32'h0000_0000);
    ext_drive[1] <= 1'b0;
    wait_cyc(8);
    rdr(IDX_STATUS);
    chk("flag on rise", rd, 32'h0000_0001);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    wr(IDX_STATUS, 32'h0000_0001);
    wait_cyc(2);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    wr(IDX_MASK, 32'h0000_0000);
    wr(IDX_CTRL, 32'h0000_0040);
    ext_drive[1] <= 1'b1;
    wait_cyc(8);
    rdr(IDX_STATUS);
    chk("flag on fall", rd, 32'h0000_0001);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    print_verdict();
  end
endmodule : settings_readback_gp_pin_mux_bench

/* hdl/pin_mux_pkg.sv */
// constants and carrier types for the settings readback pin mux
package pin_mux_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_VID_LO    = 6'h08;
  localparam logic [5:0] IDX_VID_HI    = 6'h09;
  localparam logic [5:0] IDX_PID_LO    = 6'h0a;
  localparam logic [5:0] IDX_PID_HI    = 6'h0b;
  localparam logic [5:0] IDX_POWER     = 6'h0c;
  localparam logic [5:0] IDX_CURRENT   = 6'h0d;
  localparam logic [5:0] IDX_PW1       = 6'h0e;
  localparam logic [5:0] IDX_PW2       = 6'h0f;
  localparam logic [5:0] IDX_PW3       = 6'h10;
  localparam logic [5:0] IDX_PW4       = 6'h11;
  localparam logic [5:0] IDX_PW5       = 6'h12;
  localparam logic [5:0] IDX_PW6       = 6'h13;
  localparam logic [5:0] IDX_PW7       = 6'h14;
  localparam logic [5:0] IDX_PW8       = 6'h15;
  localparam logic [5:0] IDX_PIN0      = 6'h16;
  localparam logic [5:0] IDX_PIN1      = 6'h17;
  localparam logic [5:0] IDX_PIN2      = 6'h18;
  localparam logic [5:0] IDX_CTRL      = 6'h20;
  localparam logic [5:0] IDX_STATUS    = 6'h21;
  localparam logic [5:0] IDX_MASK      = 6'h22;
  localparam logic [5:0] IDX_PIN_STATE = 6'h23;
  localparam int         NUM_SETTINGS  = 17;

  // pin settings byte fields
  localparam int OUT_VAL_BIT = 4;
  localparam int DIR_BIT     = 3;
  localparam int DESIG_MSB   = 2;

  // designation codes
  localparam logic [2:0] DESIG_GPIO   = 3'h0;
  localparam logic [2:0] P0_SUSPEND   = 3'h1;
  localparam logic [2:0] P0_RX_ACT    = 3'h2;
  localparam logic [2:0] P1_CLK_OUT   = 3'h1;
  localparam logic [2:0] P1_ADC1      = 3'h2;
  localparam logic [2:0] P1_TX_ACT    = 3'h3;
  localparam logic [2:0] P1_EDGE_IRQ  = 3'h4;
  localparam logic [2:0] P2_CONFIGURED = 3'h1;
  localparam logic [2:0] P2_ANALOG_INPUT_CHANNEL_TWO      = 3'h2;
  localparam logic [2:0] P2_ANALOG_OUTPUT_CHANNEL_ONE      = 3'h3;

  // control register fields
  localparam int          DIV_W          = 5;
  localparam int          CTRL_NEG_EDGE  = 6;
  localparam int          CTRL_POS_EDGE  = 5;
  localparam int          CTRL_RX_IDLE   = 8;
  localparam int          CTRL_TX_IDLE   = 9;
  localparam int          CTRL_SSP_IDLE  = 10;
  localparam int          CTRL_CFG_IDLE  = 11;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [7:0]  SETTING_RESET  = 8'h00;
  localparam int          STAT_EDGE      = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic adc1_sel;
    logic analog_input_channel_two_sel;
    logic analog_output_channel_one_sel;
  } analog_sel_s;

  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [7:0]  power_attributes;
    logic [8:0]  current_ma;
  } usb_desc_s;
endpackage : pin_mux_pkg

/* hdl/settings_readback_gp_pin_mux.sv */
// settings registers, general pin mux and edge interrupt behind an axi4-lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module settings_readback_gp_pin_mux (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     clk_en,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [2:0]               pin_in,
  input  wire logic                     suspend_active,
  input  wire logic                     usb_configured,
  input  wire logic                     uart_rx_active,
  input  wire logic                     uart_tx_active,
  output pin_mux_pkg::pin_drive_s       pins,
  output pin_mux_pkg::analog_sel_s      analog,
  output pin_mux_pkg::usb_desc_s        usb_desc,
  output logic                          irq
);
  import pin_mux_pkg::*;

  localparam int S0 = int'(IDX_PIN0) - int'(IDX_VID_LO);
  localparam int S1 = int'(IDX_PIN1) - int'(IDX_VID_LO);
  localparam int S2 = int'(IDX_PIN2) - int'(IDX_VID_LO);
  localparam int SC = int'(IDX_CURRENT) - int'(IDX_VID_LO);
  localparam int SW = int'(IDX_PW1) - int'(IDX_VID_LO);

  typedef struct packed {
    logic                          aw_got;
    logic                          w_got;
    logic [5:0]                    aw_idx;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    logic [NUM_SETTINGS-1:0][7:0]  cfg;
    logic [15:0]                   ctrl;
    logic [0:0]                    status;
    logic [0:0]                    mask;
    logic [2:0]                    sync1;
    logic [2:0]                    sync2;
    logic                          pin1_prev;
    logic [DIV_W-1:0]              div_cnt;
    logic                          clk_level;
    pin_drive_s                    drive;
    analog_sel_s                   ana;
    usb_desc_s                     desc;
    logic                          irq;
  } state_s;

  state_s q;
  state_s d;
  logic   wr_fire;
  logic   edge_event;

  // a write retires once address and data are both held and no answer is pending
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;

  // next state of the whole block
  always_comb begin
    logic [7:0] s;
    logic       rise;
    logic       fall;
    logic [5:0] ridx;
    s    = 8'h00;
    rise = q.sync2[1] && !q.pin1_prev;
    fall = !q.sync2[1] && q.pin1_prev;
    ridx = s_axi_araddr[7:2];
    d    = q;
    // two stages before any pin level is looked at
    d.sync1     = pin_in;
    d.sync2     = q.sync1;
    d.pin1_prev = q.sync2[1];

    // address and data channels are taken independently
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // register write; settings bytes live in lane 0
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (q.aw_idx >= IDX_VID_LO && q.aw_idx <= IDX_PIN2) begin
        if (q.wstrb[0]) begin
          d.cfg[5'(q.aw_idx - IDX_VID_LO)] = q.wdata[7:0];
        end
      end else begin
        case (q.aw_idx)
          IDX_CTRL: begin
            if (q.wstrb[0]) d.ctrl[7:0] = q.wdata[7:0];
            if (q.wstrb[1]) d.ctrl[15:8] = q.wdata[15:8];
          end
          IDX_STATUS: begin
            if (q.wstrb[0]) d.status = q.status & ~q.wdata[0:0];
          end
          IDX_MASK: begin
            if (q.wstrb[0]) d.mask = q.wdata[0:0];
          end
          IDX_PIN_STATE: d.bresp = RESP_OKAY;
          default: d.bresp = RESP_SLVERR;
        endcase
      end
    end

    edge_event = (q.cfg[S1][DESIG_MSB:0] == P1_EDGE_IRQ) &&
                 ((fall && q.ctrl[CTRL_NEG_EDGE]) || (rise && q.ctrl[CTRL_POS_EDGE]));
    // set is applied after the clear so a same-cycle event survives
    if (edge_event) begin
      d.status[STAT_EDGE] = 1'b1;
    end

    // read answers one cycle after the address is taken
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (ridx >= IDX_VID_LO && ridx <= IDX_PIN2) begin
        d.rdata[7:0] = q.cfg[5'(ridx - IDX_VID_LO)];
      end else begin
        case (ridx)
          IDX_CTRL:      d.rdata[15:0] = q.ctrl;
          IDX_STATUS:    d.rdata[0:0] = q.status;
          IDX_MASK:      d.rdata[0:0] = q.mask;
          IDX_PIN_STATE: d.rdata[11:0] = {q.ana, q.drive.oe, q.drive.out, q.sync2};
          default:       d.rresp = RESP_SLVERR;
        endcase
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // one transaction of each kind in flight at a time
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;

    // gpio part, shared by every pin
    d.drive = '0;
    d.ana   = '0;
    for (int p = 0; p < 3; p++) begin
      s = q.cfg[S0 + p];
      if (s[DESIG_MSB:0] == DESIG_GPIO) begin
        d.drive.oe[p]  = !s[DIR_BIT];
        d.drive.out[p] = s[OUT_VAL_BIT];
      end
    end

    case (q.cfg[S0][DESIG_MSB:0])
      P0_SUSPEND: begin
        d.drive.oe[0]  = 1'b1;
        d.drive.out[0] = q.ctrl[CTRL_SSP_IDLE] ^ suspend_active;
      end
      P0_RX_ACT: begin
        d.drive.oe[0]  = 1'b1;
        d.drive.out[0] = q.ctrl[CTRL_RX_IDLE] ^ uart_rx_active;
      end
      default: ;
    endcase

    case (q.cfg[S1][DESIG_MSB:0])
      P1_CLK_OUT: begin
        d.drive.oe[1]  = 1'b1;
        d.drive.out[1] = q.clk_level;
      end
      P1_ADC1:   d.ana.adc1_sel = 1'b1;
      P1_TX_ACT: begin
        d.drive.oe[1]  = 1'b1;
        d.drive.out[1] = q.ctrl[CTRL_TX_IDLE] ^ uart_tx_active;
      end
      default: ;
    endcase

    case (q.cfg[S2][DESIG_MSB:0])
      P2_CONFIGURED: begin
        d.drive.oe[2]  = 1'b1;
        d.drive.out[2] = q.ctrl[CTRL_CFG_IDLE] ^ usb_configured;
      end
      P2_ANALOG_INPUT_CHANNEL_TWO: d.ana.analog_input_channel_two_sel = 1'b1;
      P2_ANALOG_OUTPUT_CHANNEL_ONE: d.ana.analog_output_channel_one_sel = 1'b1;
      default: ;
    endcase

    // clock divider; a divider of zero parks the clock low
    if (q.cfg[S1][DESIG_MSB:0] == P1_CLK_OUT && q.ctrl[DIV_W-1:0] != '0) begin
      if (q.div_cnt >= q.ctrl[DIV_W-1:0] - 5'd1) begin
        d.div_cnt   = '0;
        d.clk_level = !q.clk_level;
      end else begin
        d.div_cnt = q.div_cnt + 5'd1;
      end
    end else begin
      d.div_cnt   = '0;
      d.clk_level = 1'b0;
    end

    // enumeration values follow the settings bytes
    d.desc.vendor_id        = {d.cfg[1], d.cfg[0]};
    d.desc.product_id       = {d.cfg[3], d.cfg[2]};
    d.desc.power_attributes = d.cfg[4];
    d.desc.current_ma       = {d.cfg[SC], 1'b0};
    d.irq                   = |(d.status & d.mask);
  end

  // the only state register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q     <= '0;
      q.cfg <= {NUM_SETTINGS{SETTING_RESET}};
      q.ctrl <= CTRL_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign pins          = q.drive;
  assign analog        = q.ana;
  assign usb_desc      = q.desc;
  assign irq           = q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_vid_high_byte: assert property (
    clk_en && wr_fire && q.aw_idx == IDX_VID_HI && q.wstrb[0]
    |=> usb_desc.vendor_id[15:8] == $past(q.wdata[7:0]))
    else $error("vendor id high byte not updated");

  a_pid_low_byte: assert property (
    clk_en && wr_fire && q.aw_idx == IDX_PID_LO && q.wstrb[0]
    |=> usb_desc.product_id[7:0] == $past(q.wdata[7:0]))
    else $error("product id low byte not updated");

  a_power_attr_match: assert property (
    clk_en && wr_fire && q.aw_idx == IDX_POWER && q.wstrb[0]
    |=> usb_desc.power_attributes == $past(q.wdata[7:0]))
    else $error("power attributes differ from setting");

  a_current_twice: assert property (
    clk_en && wr_fire && q.aw_idx == IDX_CURRENT && q.wstrb[0]
    |=> usb_desc.current_ma == 9'(2 * $past(q.wdata[7:0])))
    else $error("requested current is not twice the setting");

  a_password_first: assert property (
    clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == IDX_PW1
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q.cfg[SW]))
    else $error("password byte 1 readback wrong");

  // gpio output level; sampled aresetn skips the release edge, whose state is still reset
  a_gpio_out_level: assert property (
    aresetn && clk_en && q.cfg[S2][DESIG_MSB:0] == DESIG_GPIO && !q.cfg[S2][DIR_BIT]
    |=> pins.oe[2] && pins.out[2] == $past(q.cfg[S2][OUT_VAL_BIT]))
    else $error("gpio output level wrong");

  a_gpio_input_dir: assert property (
    clk_en && q.cfg[S0][DESIG_MSB:0] == DESIG_GPIO && q.cfg[S0][DIR_BIT]
    |=> !pins.oe[0])
    else $error("gpio input pin is driven");

  a_suspend_drive: assert property (
    clk_en && q.cfg[S0][DESIG_MSB:0] == P0_SUSPEND
    |=> pins.oe[0] && pins.out[0] == ($past(q.ctrl[CTRL_SSP_IDLE]) ^ $past(suspend_active)))
    else $error("suspend indicator wrong");

  a_adc1_select: assert property (
    clk_en && q.cfg[S1][DESIG_MSB:0] == P1_ADC1 |=> analog.adc1_sel && !pins.oe[1])
    else $error("analog input one not selected");

  a_analog_output_channel_one_select: assert property (
    clk_en && q.cfg[S2][DESIG_MSB:0] == P2_ANALOG_OUTPUT_CHANNEL_ONE |=> analog.analog_output_channel_one_sel && !pins.oe[2])
    else $error("analog output one not selected");

  a_clk_toggle: assert property (
    clk_en && q.cfg[S1][DESIG_MSB:0] == P1_CLK_OUT && q.ctrl[DIV_W-1:0] == 5'd1
    ##1 clk_en && q.cfg[S1][DESIG_MSB:0] == P1_CLK_OUT && q.ctrl[DIV_W-1:0] == 5'd1
    |=> pins.out[1] != $past(pins.out[1]))
    else $error("clock output did not toggle");

  a_edge_sets_flag: assert property (
    clk_en && edge_event |=> q.status[STAT_EDGE] ##1 irq == $past(q.mask[0]) || !clk_en)
    else $error("edge event lost");

  a_tx_activity: assert property (
    clk_en && q.cfg[S1][DESIG_MSB:0] == P1_TX_ACT
    |=> pins.oe[1] && pins.out[1] == ($past(q.ctrl[CTRL_TX_IDLE]) ^ $past(uart_tx_active)))
    else $error("transmit activity level wrong");

  a_unlisted_input: assert property (
    clk_en && q.cfg[S0][DESIG_MSB:0] > P0_RX_ACT |=> !pins.oe[0])
    else $error("unlisted designation drives pin");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done:  cover property (s_axi_rvalid && s_axi_rready);
  c_irq_raise:  cover property (!irq ##1 irq);
  c_clk_out:    cover property (q.cfg[S1][DESIG_MSB:0] == P1_CLK_OUT && pins.out[1]);
endmodule : settings_readback_gp_pin_mux
